// ### air_pkg.sv
// Purpose: Shared constants and types for the accessory event mask and timing registers.
// Assumes: Registers are reached over the two-wire serial target port at one 8-bit address space.
// Notes: Offsets are the byte addresses on the serial bus.
// How it works
// - Status two read-clears; events set bits.
// - Mask one: read/write, resets zero.
// - Mask two: bits 4:1 writable, resets zero.
// - Read-only id resistance code, reset 1f.
// - Timing one: press and detect fields.
package air_pkg;
    localparam logic [6:0] AIR_DEV_ADDR = 7'h25;
    localparam logic [7:0] AIR_OFS_STATUS_TWO = 8'h04;
    localparam logic [7:0] AIR_OFS_MASK_ONE = 8'h05;
    localparam logic [7:0] AIR_OFS_MASK_TWO = 8'h06;
    localparam logic [7:0] AIR_OFS_ID_CODE = 8'h07;
    localparam logic [7:0] AIR_OFS_TIMING_ONE = 8'h08;
    localparam logic [7:0] AIR_OFS_TIMING_TWO = 8'h09;
    localparam logic [7:0] AIR_RST_STATUS_TWO = 8'h00;
    localparam logic [7:0] AIR_RST_MASK = 8'h00;
    localparam logic [7:0] AIR_RST_ID_CODE = 8'h1f;
    localparam logic [7:0] AIR_RST_TIMING = 8'h00;
    localparam logic [7:0] AIR_STAT2_USED = 8'h1e;
    localparam int AIR_STAT2_LSB = 1;
    localparam int AIR_ID_CODE_W = 5;
    localparam logic [3:0] AIR_BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        AIR_IDLE = 4'b0000,
        AIR_ADDR = 4'b0001,
        AIR_ADDR_ACK = 4'b0010,
        AIR_REG = 4'b0011,
        AIR_REG_ACK = 4'b0100,
        AIR_WDATA = 4'b0101,
        AIR_WDATA_ACK = 4'b0110,
        AIR_TX = 4'b0111,
        AIR_TX_ACK = 4'b1000
    } air_state_t;
endpackage

// ### air_bus_if.sv
// Purpose: Byte access path between the serial target engine and the register file.
// Assumes: Strobes are one-cycle and combinational from the engine.
// Notes: Read data is combinational from the register file.
interface air_bus_if;
    logic rd_stb;
    logic wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport engine (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
    modport regs (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface

// ### air_reg_file.sv
// Purpose: Holds status two, both masks, the id resistance code and both timing registers.
// Assumes: Event inputs are synchronous one-cycle or level requests from the detection logic.
// Notes: Reserved bits are stored as zero and read as zero.
module air_reg_file #(
    parameter int ID_W = air_pkg::AIR_ID_CODE_W
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    air_bus_if.regs bus,
    input wire logic [3:0] events_i,
    input wire logic [ID_W-1:0] id_code_i,
    output logic [7:0] status_two_o,
    output logic [7:0] mask_one_o,
    output logic [7:0] mask_two_o,
    output logic [7:0] id_code_o,
    output logic [7:0] timing_one_o,
    output logic [7:0] timing_two_o
);
    import air_pkg::*;

    typedef struct packed {
        logic [7:0] s2;
        logic [7:0] m1;
        logic [7:0] m2;
        logic [7:0] id;
        logic [7:0] t1;
        logic [7:0] t2;
    } air_regs_t;

    air_regs_t r;
    air_regs_t next_r;

    if (ID_W < 1 || ID_W > 8) begin : g_bad_width
        $error("id code width must be 1 to 8");
    end

    function automatic logic [7:0] read_mux(input logic [7:0] a, input air_regs_t q);
        case (a)
            AIR_OFS_STATUS_TWO: read_mux = q.s2;
            AIR_OFS_MASK_ONE: read_mux = q.m1;
            AIR_OFS_MASK_TWO: read_mux = q.m2;
            AIR_OFS_ID_CODE: read_mux = q.id;
            AIR_OFS_TIMING_ONE: read_mux = q.t1;
            AIR_OFS_TIMING_TWO: read_mux = q.t2;
            default: read_mux = 8'h00;
        endcase
    endfunction

    assign bus.rdata = read_mux(bus.addr, r);

    always_comb begin
        next_r = r;
        next_r.id = 8'h00;
        next_r.id[ID_W-1:0] = id_code_i;
        if (bus.wr_stb) begin
            case (bus.addr)
                AIR_OFS_MASK_ONE: next_r.m1 = bus.wdata;
                AIR_OFS_MASK_TWO: next_r.m2 = bus.wdata & AIR_STAT2_USED;
                AIR_OFS_TIMING_ONE: next_r.t1 = bus.wdata;
                AIR_OFS_TIMING_TWO: next_r.t2 = bus.wdata;
                default: next_r.t2 = r.t2;
            endcase
        end
        if (bus.rd_stb && bus.addr == AIR_OFS_STATUS_TWO) begin
            next_r.s2 = AIR_RST_STATUS_TWO;
        end
        next_r.s2 = next_r.s2 | ({4'h0, events_i} << AIR_STAT2_LSB);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '{s2: AIR_RST_STATUS_TWO, m1: AIR_RST_MASK, m2: AIR_RST_MASK,
                   id: AIR_RST_ID_CODE, t1: AIR_RST_TIMING, t2: AIR_RST_TIMING};
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign status_two_o = r.s2;
    assign mask_one_o = r.m1;
    assign mask_two_o = r.m2;
    assign id_code_o = r.id;
    assign timing_one_o = r.t1;
    assign timing_two_o = r.t2;
endmodule

// ### air_regs_top.sv
// Purpose: Two-wire serial target that reaches the accessory mask, status and timing registers.
// Assumes: Serial lines are synchronous to sys_clk_i and held stable for several clocks per phase.
// Notes: The data line is open drain; the pin is pulled low while sda_oe_o is high.
module air_regs_top #(
    parameter int ID_W = air_pkg::AIR_ID_CODE_W
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic stuck_key_recovered_i,
    input wire logic stuck_key_detected_i,
    input wire logic valid_resistance_i,
    input wire logic reserved_attach_i,
    input wire logic [ID_W-1:0] id_code_i,
    output logic [7:0] status_two_o,
    output logic [7:0] mask_one_o,
    output logic [7:0] mask_two_o,
    output logic [7:0] id_code_o,
    output logic [3:0] press_time_o,
    output logic [3:0] detect_time_o,
    output logic [3:0] wait_time_o,
    output logic [3:0] long_press_time_o
);
    import air_pkg::*;

    typedef struct packed {
        air_state_t st;
        logic scl_q;
        logic sda_q;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic rw;
        logic ack;
        logic oe;
        logic sda;
    } air_ctl_t;

    // Both line copies reset to the idle high level, so no false START follows reset.
    localparam air_ctl_t AIR_CTL_RST = '{
        st: AIR_IDLE,
        scl_q: 1'b1,
        sda_q: 1'b1,
        sh: 8'h00,
        cnt: 4'h0,
        ptr: 8'h00,
        rw: 1'b0,
        ack: 1'b0,
        oe: 1'b0,
        sda: 1'b0
    };

    logic [1:0] rst_sync;
    logic rst_n;
    air_ctl_t r;
    air_ctl_t next_r;
    logic [7:0] timing_one;
    logic [7:0] timing_two;

    air_bus_if bus ();

    // The id code travels in one byte-wide register.
    if (ID_W < 1 || ID_W > 8) begin : g_bad_id_width
        $error("id code width must be 1 to 8");
    end

    function automatic logic byte_full(input logic [3:0] c);
        byte_full = (c == AIR_BITS_PER_BYTE);
    endfunction

    // The register pointer wraps from the top address back to zero.
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        ptr_step = p + 8'h01;
    endfunction

    // The reset synchroniser keeps running while the clock enable is low.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Line edges are judged against the levels taken on the last enabled cycle.
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        next_r = r;
        bus.rd_stb = 1'b0;
        bus.wr_stb = 1'b0;
        bus.addr = r.ptr;
        bus.wdata = r.sh;
        rise = !r.scl_q && scl_i;
        fall = r.scl_q && !scl_i;
        start = r.scl_q && scl_i && r.sda_q && !sda_i;
        stop = r.scl_q && scl_i && !r.sda_q && sda_i;
        next_r.scl_q = scl_i;
        next_r.sda_q = sda_i;
        case (r.st)
            AIR_ADDR, AIR_REG, AIR_WDATA: begin
                if (rise) begin
                    next_r.sh = {r.sh[6:0], sda_i};
                    next_r.cnt = r.cnt + 4'h1;
                end else if (fall && byte_full(r.cnt)) begin
                    next_r.oe = 1'b1;
                    if (r.st == AIR_ADDR) begin
                        next_r.rw = r.sh[0];
                        next_r.st = (r.sh[7:1] == AIR_DEV_ADDR) ? AIR_ADDR_ACK : AIR_IDLE;
                        next_r.oe = (r.sh[7:1] == AIR_DEV_ADDR);
                    end else if (r.st == AIR_REG) begin
                        next_r.ptr = r.sh;
                        next_r.st = AIR_REG_ACK;
                    end else begin
                        bus.wr_stb = 1'b1;
                        next_r.ptr = ptr_step(r.ptr);
                        next_r.st = AIR_WDATA_ACK;
                    end
                end
            end
            AIR_ADDR_ACK, AIR_TX_ACK: begin
                if (rise) begin
                    next_r.ack = !sda_i;
                end else if (fall) begin
                    next_r.cnt = 4'h0;
                    next_r.oe = 1'b0;
                    if (r.rw && (r.st == AIR_ADDR_ACK || r.ack)) begin
                        // Loading a byte is the read that clears status two.
                        bus.rd_stb = 1'b1;
                        next_r.sh = bus.rdata;
                        next_r.oe = !bus.rdata[7];
                        next_r.ptr = ptr_step(r.ptr);
                        next_r.st = AIR_TX;
                    end else begin
                        next_r.st = r.rw ? AIR_IDLE : AIR_REG;
                    end
                end
            end
            // The acknowledge is let go on the falling edge that ends its pulse.
            AIR_REG_ACK, AIR_WDATA_ACK: begin
                if (fall) begin
                    next_r.cnt = 4'h0;
                    next_r.oe = 1'b0;
                    next_r.st = AIR_WDATA;
                end
            end
            AIR_TX: begin
                if (rise) begin
                    next_r.cnt = r.cnt + 4'h1;
                end else if (fall) begin
                    if (byte_full(r.cnt)) begin
                        next_r.oe = 1'b0;
                        next_r.st = AIR_TX_ACK;
                    end else begin
                        // The next bit goes out one cycle after the falling edge is seen.
                        next_r.sh = {r.sh[6:0], 1'b0};
                        next_r.oe = !r.sh[6];
                    end
                end
            end
            default: next_r.st = AIR_IDLE;
        endcase
        // A START or STOP ends whatever byte was in flight.
        if (start) begin
            next_r.st = AIR_ADDR;
            next_r.cnt = 4'h0;
            next_r.oe = 1'b0;
        end else if (stop) begin
            next_r.st = AIR_IDLE;
            next_r.oe = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r <= AIR_CTL_RST;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    air_reg_file #(
        .ID_W(ID_W)
    ) u_regs (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .bus(bus.regs),
        .events_i({stuck_key_recovered_i, stuck_key_detected_i, valid_resistance_i,
                   reserved_attach_i}),
        .id_code_i(id_code_i),
        .status_two_o(status_two_o),
        .mask_one_o(mask_one_o),
        .mask_two_o(mask_two_o),
        .id_code_o(id_code_o),
        .timing_one_o(timing_one),
        .timing_two_o(timing_two)
    );

    // The open-drain data pin never drives high, so sda_o stays low.
    assign sda_o = r.sda;
    assign sda_oe_o = r.oe;
    assign press_time_o = timing_one[7:4];
    assign detect_time_o = timing_one[3:0];
    assign wait_time_o = timing_two[7:4];
    assign long_press_time_o = timing_two[3:0];
endmodule

// ### air_regs_assertions.sv
// Purpose: Port assertions for the register bank.
// Assumes: One clock; reset leaves the design through two flops.
// Notes: up counts edges since reset release and holds at 3.
module air_regs_assertions #(
    parameter int ID_W = 5
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic stuck_key_recovered_i,
    input wire logic stuck_key_detected_i,
    input wire logic valid_resistance_i,
    input wire logic reserved_attach_i,
    input wire logic [ID_W-1:0] id_code_i,
    input wire logic [7:0] status_two_o,
    input wire logic [7:0] mask_one_o,
    input wire logic [7:0] mask_two_o,
    input wire logic [7:0] id_code_o
);
    logic [1:0] up;
    logic [3:0] ev;
    logic run;
    assign ev = {stuck_key_recovered_i, stuck_key_detected_i, valid_resistance_i,
                 reserved_attach_i};
    assign run = (up == 2'd3);
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up <= 2'd0;
        end else if (!run) begin
            up <= up + 2'd1;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_reset_values: assert property (up == 2'd1 |-> status_two_o == 8'h00 &&
        mask_one_o == 8'h00 && mask_two_o == 8'h00 && id_code_o == 8'h1f)
        else $error("register not at reset value");
    a_event_sets: assert property (run && ce_i |=>
        (status_two_o[4:1] & $past(ev)) == $past(ev)) else $error("event bit not set");
    a_status_rsvd: assert property (status_two_o[7:5] == 3'h0 && !status_two_o[0])
        else $error("status reserved bit set");
    a_mask_rsvd: assert property (mask_two_o[7:5] == 3'h0 && !mask_two_o[0])
        else $error("mask two reserved bit set");
    a_id_follow: assert property (run && ce_i |=> id_code_o == 8'($past(id_code_i)))
        else $error("id code not copied");
    a_ce_freeze: assert property (run && !ce_i |=> $stable(status_two_o) &&
        $stable(mask_one_o)) else $error("state moved with enable low");
    a_mask_at_low: assert property (run && $changed(mask_one_o) |-> !scl_i)
        else $error("mask changed with clock high");
    a_ack_at_low: assert property (run && $changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved with clock high");
    c_event: cover property (run && ev != 4'h0);
    c_ack: cover property ($rose(sda_oe_o));
    c_mask: cover property (run && $changed(mask_one_o));
endmodule

bind air_regs_top air_regs_assertions #(.ID_W(ID_W)) u_chk (
    .sys_clk_i, .arst_n_i, .ce_i, .scl_i, .sda_oe_o, .stuck_key_recovered_i,
    .stuck_key_detected_i, .valid_resistance_i, .reserved_attach_i, .id_code_i,
    .status_two_o, .mask_one_o, .mask_two_o, .id_code_o
);

// ### air_host.sv
// Purpose: Host controller model on the two-wire serial bus.
// Assumes: The data line has a pull-up; the model only pulls it low.
// Notes: ph is the clock phase in cycles; raise it for a slow host.
module air_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int ph = 4;
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic start();
        sda_pull_o = 1'b0;
        tick(ph);
        scl_o = 1'b1;
        tick(ph);
        sda_pull_o = 1'b1;
        tick(ph);
        scl_o = 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_pull_o = 1'b1;
        tick(ph);
        scl_o = 1'b1;
        tick(ph);
        sda_pull_o = 1'b0;
        tick(ph);
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_pull_o = ~b;
        tick(ph);
        scl_o = 1'b1;
        tick(ph);
        r = sda_i;
        scl_o = 1'b0;
        tick(1);
    endtask
    task automatic xbyte(input logic [7:0] b, input logic last, output logic [7:0] r,
                         output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
        bit_x(last, a);
        ack = ~a;
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$],
                      output logic ack);
        logic [7:0] r;
        start();
        xbyte({dev, 1'b0}, 1'b1, r, ack);
        if (ack) begin
            xbyte(ptr, 1'b1, r, ack);
            foreach (d[i]) xbyte(d[i], 1'b1, r, ack);
        end
        stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
        logic [7:0] r;
        logic a;
        q = {};
        start();
        xbyte({air_pkg::AIR_DEV_ADDR, 1'b0}, 1'b1, r, a);
        xbyte(ptr, 1'b1, r, a);
        start();
        xbyte({air_pkg::AIR_DEV_ADDR, 1'b1}, 1'b1, r, a);
        for (int i = 0; i < n; i++) begin
            xbyte(8'hff, i == n - 1, r, a);
            q.push_back(r);
        end
        stop();
    endtask
endmodule

// ### tb.sv
// Purpose: Self-checking bench for the accessory register bank.
// Assumes: Host model drives the serial lines; the data line has a pull-up.
// Notes: Events and id code are driven by the bench.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import air_pkg::*;
    logic sys_clk_i = 1'b0;
    logic arst_n_i;
    logic ce_i;
    logic [3:0] ev;
    logic [4:0] id_in;
    logic ev_rec, ev_det, ev_val, ev_att;
    logic scl, pull, sda_oe, sda_drv, ack;
    logic [7:0] st2, m1, m2, idc;
    logic [3:0] pt, dt, wt, lt;
    logic [7:0] q[$];
    wire logic sda_line = ~(pull | sda_oe);
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    assign {ev_rec, ev_det, ev_val, ev_att} = ev;
    air_host host (.clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(pull));
    air_regs_top DUT (.sys_clk_i, .arst_n_i, .ce_i, .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_drv), .sda_oe_o(sda_oe), .stuck_key_recovered_i(ev_rec),
        .stuck_key_detected_i(ev_det), .valid_resistance_i(ev_val),
        .reserved_attach_i(ev_att), .id_code_i(id_in),
        .status_two_o(st2), .mask_one_o(m1), .mask_two_o(m2), .id_code_o(idc),
        .press_time_o(pt), .detect_time_o(dt), .wait_time_o(wt), .long_press_time_o(lt));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_q(input logic [7:0] exp[$]);
        foreach (exp[i]) chk(q[i], exp[i]);
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic t_reset();
        chk({pt, dt}, 8'h00);
        chk({wt, lt}, 8'h00);
        host.rd(8'h04, 6, q);
        chk_q('{8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00});
    endtask
    task automatic t_write();
        host.ph = 8;
        host.wr(AIR_DEV_ADDR, 8'h05, '{8'ha5, 8'hff, 8'h77, 8'h5a, 8'hc3}, ack);
        host.ph = 4;
        chk({7'h0, ack}, 8'h01);
        chk(m1, 8'ha5);
        chk(m2, 8'h1e);
        chk(idc, 8'h1f);
        chk({pt, dt}, 8'h5a);
        chk({wt, lt}, 8'hc3);
        host.rd(8'h05, 5, q);
        chk_q('{8'ha5, 8'h1e, 8'h1f, 8'h5a, 8'hc3});
    endtask
    task automatic t_status();
        for (int i = 0; i < 4; i++) begin
            ev = 4'h1 << i;
            host.tick(1);
            ev = 4'h0;
            host.tick(1);
            chk(st2, 8'h02 << i);
            host.rd(8'h04, 2, q);
            chk_q('{8'h02 << i, 8'ha5});
            chk(st2, 8'h00);
        end
    endtask
    task automatic t_id();
        id_in = 5'h0a;
        host.tick(2);
        chk(idc, 8'h0a);
        host.rd(8'h07, 1, q);
        chk(q[0], 8'h0a);
    endtask
    task automatic t_refuse();
        host.wr(7'h26, 8'h05, '{8'h00}, ack);
        chk({7'h0, ack}, 8'h00);
        chk(m1, 8'ha5);
        host.wr(AIR_DEV_ADDR, 8'h04, '{8'hff}, ack);
        chk(st2, 8'h00);
        ce_i = 1'b0;
        ev = 4'hf;
        host.tick(2);
        ev = 4'h0;
        ce_i = 1'b1;
        host.tick(1);
        chk(st2, 8'h00);
    endtask
    task automatic t_rearm();
        arst_n_i = 1'b0;
        host.tick(2);
        chk(m1, 8'h00);
        arst_n_i = 1'b1;
        host.tick(1);
        chk(idc, 8'h1f);
        host.tick(4);
        chk(idc, 8'h0a);
        chk(m2, 8'h00);
        chk({pt, dt}, 8'h00);
        chk({wt, lt}, 8'h00);
        chk({7'h0, sda_drv}, 8'h00);
        host.wr(AIR_DEV_ADDR, 8'h05, '{8'h3c}, ack);
        chk(m1, 8'h3c);
    endtask
    initial begin
        arst_n_i = 1'b0;
        ce_i = 1'b1;
        ev = 4'h0;
        id_in = 5'h1f;
        repeat (5) @(posedge sys_clk_i);
        #1;
        arst_n_i = 1'b1;
        host.tick(8);
        t_reset();
        t_write();
        t_status();
        t_id();
        t_refuse();
        t_rearm();
        summarize();
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            summarize();
        end
    end
endmodule
